// >>> flash_array_model.sv
// Behavioural model of the flash array and its write latches.
// Assumes the controller writes device words over a one-cycle strobe.
`timescale 1ns/1ps
module flash_array_model
    import flash_seq_pkg::*;
#(
    parameter int OP_CYC = OP_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Device register port
    input  wire logic [3:0]  dev_addr,
    input  wire logic [15:0] dev_wdata,
    input  wire logic        dev_write
);
    logic [15:0] ctrl;        // Control word, start bit included
    logic [15:0] page;        // Upper row address
    logic [15:0] offset;      // In-page row address
    logic [15:0] latch [32];  // Write latches, one row
    logic [5:0]  n_latch;     // Latch words loaded since last launch
    logic [1:0]  key_st;      // 0 none, 1 first key, 2 both keys
    logic [1:0]  adr_seen;    // Page and offset written since launch
    int          timer;       // Cycles since launch
    int          launches;    // Accepted starts
    int          errs;        // Protocol faults seen
    ////////////////////////////////////////////////////////////////////
    // Register writes and operation timing
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl = 16'h0000; page = 16'h0000; offset = 16'h0000;
            n_latch = 6'h00; key_st = 2'h0; adr_seen = 2'h0;
            timer = 0; launches = 0; errs = 0;
        end
        else
        begin
            // start bit clears after the nominal time
            if (ctrl[START_BIT])
            begin
                timer = timer + 1;
                if (timer >= OP_CYC) ctrl[START_BIT] = 1'b0;
            end
            // nothing may be written while the array is busy
            if (dev_write && ctrl[START_BIT]) errs = errs + 1;
            else if (dev_write)
            begin
                // the key pair must come in order, just before start
                if (dev_addr == DEV_KEY)
                    key_st = (dev_wdata == KEY_FIRST) ? 2'h1 :
                             (dev_wdata == KEY_SECOND && key_st == 2'h1) ? 2'h2 : 2'h0;
                else if (dev_addr == DEV_PAGE)
                begin
                    page = dev_wdata; adr_seen[1] = 1'b1; key_st = 2'h0;
                end
                else if (dev_addr == DEV_OFFSET)
                begin
                    offset = dev_wdata; adr_seen[0] = 1'b1; key_st = 2'h0;
                end
                else if (dev_addr == DEV_LATCH)
                begin
                    latch[n_latch[4:0]] = dev_wdata; n_latch = n_latch + 6'h01; key_st = 2'h0;
                end
                // start only with keys, write enable and a set-up row
                else if (dev_addr == DEV_CTRL)
                begin
                    if (dev_wdata[14:0] != CTRL_ERASE[14:0] && dev_wdata[14:0] != CTRL_PROGRAM[14:0])
                        errs = errs + 1;
                    if (dev_wdata[START_BIT] && !(key_st == 2'h2 && dev_wdata[WRITE_ENABLE_BIT_BIT]))
                        errs = errs + 1;
                    else if (dev_wdata[START_BIT])
                    begin
                        if (dev_wdata == (CTRL_ERASE | START_MASK) && adr_seen != 2'h3) errs = errs + 1;
                        if (dev_wdata == (CTRL_PROGRAM | START_MASK) && n_latch != 6'd32) errs = errs + 1;
                        launches = launches + 1; timer = 0; n_latch = 6'h00; adr_seen = 2'h0;
                    end
                    ctrl = dev_wdata; key_st = 2'h0;
                end
                else errs = errs + 1;
            end
        end
    end
endmodule : flash_array_model

// >>> flash_row_program_sequencer.sv
// Controller that drives the flash row sequencer over its register port.
// Assumes the device takes a one-cycle write strobe and that the latch
// data is pushed word by word to the latch register.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module flash_row_program_sequencer
    import flash_seq_pkg::*;
#(
    // Operation length in clock cycles; the default is the nominal 2 ms
    parameter logic [CNT_W-1:0] OP_LEN = CNT_W'(OP_CYCLES)
)
(
    // Clock, enable and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // Software port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_write,
    input  wire logic        sw_read,
    output logic      [15:0] sw_rdata,
    // Device register port
    output logic      [3:0]  dev_addr,
    output logic      [15:0] dev_wdata,
    output logic             dev_write,
    // Stall seen by the processor
    output logic             cpu_stall
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [9:0]
    {
        ST_IDLE   = 10'h001,
        ST_LATCH  = 10'h002,
        ST_CTRL   = 10'h004,
        ST_PAGE   = 10'h008,
        ST_OFFSET = 10'h010,
        ST_KEY1   = 10'h020,
        ST_KEY2   = 10'h040,
        ST_START  = 10'h080,
        ST_GAP    = 10'h100,
        ST_WAIT   = 10'h200
    } seq_state_type;

    typedef struct packed
    {
        seq_state_type fsm;          // Sequencer position
        logic          is_prog;      // Current op is a program
        logic [15:0]   page;         // Row page address
        logic [15:0]   offset;       // In-page address
        logic [4:0]    wr_index;     // Image write pointer
        logic [5:0]    lat_index;    // Latch push counter
        logic [1:0]    gap;          // Idle cycles after start
        logic          start_flag;   // Mirror of the start bit
        logic          done_flag;    // Last operation finished
        logic [3:0]    dev_addr;
        logic [15:0]   dev_wdata;
        logic          dev_write;
        logic [15:0]   rdata;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;

    // Row image, one row of words
    logic [15:0] image [0:ROW_WORDS-1];

    logic timer_busy;
    logic timer_done;
    logic timer_start;

    // Device write helper, one strobe per call
    function automatic ctrl_state_type dev_put(input ctrl_state_type s,
                                               input logic [3:0] a,
                                               input logic [15:0] d);
        ctrl_state_type r;
        r           = s;
        r.dev_addr  = a;
        r.dev_wdata = d;
        r.dev_write = 1'b1;
        return r;
    endfunction : dev_put

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_state           = state;
        next_state.dev_write = 1'b0;
        timer_start          = 1'b0;
        // Register reads answer in the next cycle
        if (sw_read)
        begin
            if (sw_addr == REG_PAGE)
                next_state.rdata = state.page;
            else if (sw_addr == REG_OFFSET)
                next_state.rdata = state.offset;
            else if (sw_addr == REG_STATUS)
                next_state.rdata = {state.start_flag, 13'h0000, state.done_flag,
                                    state.fsm != ST_IDLE};
            else if (sw_addr == REG_INDEX)
                next_state.rdata = {11'h000, state.wr_index};
            else
                next_state.rdata = 16'h0000;
        end
        // Software writes to addresses and image while idle only
        if (sw_write && state.fsm == ST_IDLE)
        begin
            if (sw_addr == REG_PAGE)
                next_state.page = sw_wdata;
            else if (sw_addr == REG_OFFSET)
                next_state.offset = sw_wdata;
            else if (sw_addr == REG_DATA)
                next_state.wr_index = state.wr_index + 5'h01;
            else if (sw_addr == REG_INDEX)
                next_state.wr_index = sw_wdata[4:0];
        end
        case (state.fsm)
            ST_IDLE:
            begin
                // Command picks erase or program; both bits set is ignored
                if (sw_write && sw_addr == REG_CMD &&
                    (sw_wdata[CMD_ERASE_BIT] ^ sw_wdata[CMD_PROG_BIT]))
                begin
                    next_state.is_prog   = sw_wdata[CMD_PROG_BIT];
                    next_state.done_flag = 1'b0;
                    next_state.lat_index = 6'h00;
                    next_state.fsm = sw_wdata[CMD_PROG_BIT] ? ST_LATCH : ST_CTRL;
                end
            end
            ST_LATCH:
            begin
                next_state = dev_put(next_state, DEV_LATCH, image[state.lat_index[4:0]]);
                if (state.lat_index == ROW_LAST)
                    next_state.fsm = ST_CTRL;
                next_state.lat_index = state.lat_index + 6'h01;
            end
            ST_CTRL:
            begin
                next_state     = dev_put(next_state, DEV_CTRL,
                                         state.is_prog ? CTRL_PROGRAM : CTRL_ERASE);
                next_state.fsm = state.is_prog ? ST_KEY1 : ST_PAGE;
            end
            ST_PAGE:
            begin
                next_state     = dev_put(next_state, DEV_PAGE, state.page);
                next_state.fsm = ST_OFFSET;
            end
            ST_OFFSET:
            begin
                next_state     = dev_put(next_state, DEV_OFFSET, state.offset);
                next_state.fsm = ST_KEY1;
            end
            ST_KEY1:
            begin
                // key, key, start back to back
                next_state     = dev_put(next_state, DEV_KEY, KEY_FIRST);
                next_state.fsm = ST_KEY2;
            end
            ST_KEY2:
            begin
                next_state     = dev_put(next_state, DEV_KEY, KEY_SECOND);
                next_state.fsm = ST_START;
            end
            ST_START:
            begin
                next_state = dev_put(next_state, DEV_CTRL,
                                     (state.is_prog ? CTRL_PROGRAM : CTRL_ERASE) | START_MASK);
                next_state.start_flag = 1'b1;
                next_state.gap        = 2'h0;
                timer_start           = 1'b1;
                next_state.fsm        = ST_GAP;
            end
            ST_GAP:
            begin
                next_state.gap = state.gap + 2'h1;
                if (state.gap == 2'h1)
                    next_state.fsm = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (timer_done)
                begin
                    next_state.start_flag = 1'b0;
                    next_state.done_flag  = 1'b1;
                    next_state.fsm        = ST_IDLE;
                end
            end
            default:
            begin
                next_state.fsm = ST_IDLE;
            end
        endcase
    end

    // Registered state, frozen while the enable is low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= '0;
            state.fsm <= ST_IDLE;
        end
        else if (clk_en)
        begin
            state <= next_state;
        end
    end

    // Image store, written only while idle
    always_ff @(posedge clk)
    begin
        if (clk_en && sw_write && sw_addr == REG_DATA && state.fsm == ST_IDLE)
        begin
            image[state.wr_index] <= sw_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer and outputs
    op_timer #(.LIMIT(OP_LEN)) u_timer
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (clk_en),
        .start  (timer_start),
        .busy   (timer_busy),
        .done   (timer_done)
    );

    assign sw_rdata  = state.rdata;
    assign dev_addr  = state.dev_addr;
    assign dev_wdata = state.dev_wdata;
    assign dev_write = state.dev_write;
    assign cpu_stall = state.fsm == ST_START || state.fsm == ST_GAP ||
                       state.fsm == ST_WAIT;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // key pair precedes start
    key_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state.fsm == ST_START) |-> $past(state.fsm) == ST_KEY2)
        else $error("start not preceded by second key");
    start_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state.dev_write && state.dev_addr == DEV_CTRL && state.start_flag &&
         $past(state.fsm) == ST_START) |-> state.dev_wdata[START_BIT] && state.dev_wdata[WRITE_ENABLE_BIT_BIT])
        else $error("start write lacks start or enable bit");
    stall_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        timer_busy |-> cpu_stall)
        else $error("stall released during operation");
    start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(state.start_flag) |-> state.done_flag && state.fsm == ST_IDLE)
        else $error("start flag cleared without completion");
    erase_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state.dev_write && state.dev_addr == DEV_CTRL && !state.is_prog &&
         !state.start_flag) |-> state.dev_wdata == CTRL_ERASE)
        else $error("erase control value wrong");
    // timer stays busy for at least eight cycles after it starts
    op_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(timer_busy) |-> timer_busy [*8])
        else $error("operation ended too early");
    gap_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state.fsm == ST_START) ##1 clk_en |=> state.fsm == ST_GAP)
        else $error("gap after start too short");
    // row push ends at last word
    row_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state.fsm == ST_CTRL && $past(state.fsm) == ST_LATCH) |->
        state.lat_index == 6'h20)
        else $error("row push count wrong");
endmodule : flash_row_program_sequencer

// >>> flash_row_program_sequencer_tb_top.sv
// Self-checking testbench for the flash row sequencer controller.
// Assumes flash_seq_pkg, the design and the flash array model compiled first.
`timescale 1ns/1ps
module flash_row_program_sequencer_tb_top;
    import flash_seq_pkg::*;
    logic        clk = 1'b0;        // 100 MHz clock
    logic        rstn = 1'b0;       // Active-low reset
    logic        clk_en = 1'b1;     // Clock enable
    logic [3:0]  sw_addr = 4'h0;    // Software port
    logic [15:0] sw_wdata = 16'h0000;
    logic        sw_write = 1'b0;
    logic        sw_read = 1'b0;
    logic [15:0] sw_rdata;
    logic [3:0]  dev_addr;          // Device port
    logic [15:0] dev_wdata;
    logic        dev_write;
    logic        cpu_stall;
    int          num_errors = 0;
    int          n_tests = 0;
    int          dev_wr_cnt = 0;    // Device writes seen
    // Short operation length keeps the run brief; the design default stays at 2 ms
    localparam int SIM_OP = 2000;
    always #5 clk = ~clk;
    // Count device strobes so silent refusals can be seen
    always @(posedge clk) if (dev_write === 1'b1) dev_wr_cnt++;
    flash_row_program_sequencer #(.OP_LEN(CNT_W'(SIM_OP))) i_dut (.clk(clk), .rstn(rstn),
        .clk_en(clk_en),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
        .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
        .dev_write(dev_write), .cpu_stall(cpu_stall));
    flash_array_model #(.OP_CYC(SIM_OP)) i_dev (.clk(clk), .rstn(rstn), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_write(dev_write));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    // One-cycle write strobe
    task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_write <= 1'b1; sw_addr <= a; sw_wdata <= d;
        @(posedge clk);
        sw_write <= 1'b0;
    endtask : sw_wr
    // One-cycle read; data stands from the next cycle until the next read
    task automatic sw_rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
                         input string nm);
        @(posedge clk);
        sw_read <= 1'b1; sw_addr <= a;
        @(posedge clk);
        sw_read <= 1'b0;
        #1 chk16(nm, e, sw_rdata & m);
    endtask : sw_rd
    // Bounded wait for the stall level; a timeout ends the run
    task automatic wait_stall(input logic lvl, input int max, output int n);
        n = 0;
        while (cpu_stall !== lvl && n < max)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= max)
        begin
            num_errors++;
            $display("[ERR] stall wait expected %b seen %b", lvl, cpu_stall);
            end_of_test();
        end
    endtask : wait_stall
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_regs;
        chk1("stall after reset", 1'b0, cpu_stall);
        sw_rd(REG_STATUS, 16'hFFFF, 16'h0000, "status reset");
        sw_rd(4'hF, 16'hFFFF, 16'h0000, "unmapped read");
        sw_wr(REG_PAGE, 16'h0012);
        sw_wr(REG_OFFSET, 16'h3400);
        sw_wr(REG_INDEX, 16'h003F);
        sw_rd(REG_PAGE, 16'hFFFF, 16'h0012, "page");
        sw_rd(REG_OFFSET, 16'hFFFF, 16'h3400, "offset");
        sw_rd(REG_INDEX, 16'hFFFF, 16'h001F, "index");
        // Frozen clock enable must drop the write
        @(posedge clk) clk_en <= 1'b0;
        sw_wr(REG_PAGE, 16'hFFFF);
        @(posedge clk) clk_en <= 1'b1;
        sw_rd(REG_PAGE, 16'hFFFF, 16'h0012, "page frozen");
    endtask : t_reset_and_regs
    task automatic t_bad_cmd;
        sw_wr(REG_CMD, 16'h0000);
        sw_wr(REG_CMD, 16'h0003);
        repeat (10) @(posedge clk);
        chk16("dev writes", 16'd0, 16'(dev_wr_cnt));
        sw_rd(REG_STATUS, 16'hFFFF, 16'h0000, "status bad cmd");
    endtask : t_bad_cmd
    task automatic t_erase;
        int n;
        sw_wr(REG_CMD, 16'h0001);
        wait_stall(1'b1, 20, n);
        // The start write reaches the array two edges after the stall rises
        repeat (2) @(posedge clk);
        #1;
        chk16("ctrl erase", CTRL_ERASE | START_MASK, i_dev.ctrl);
        chk16("launches", 16'd1, 16'(i_dev.launches));
        chk16("dev page", 16'h0012, i_dev.page);
        chk16("dev offset", 16'h3400, i_dev.offset);
        sw_rd(REG_STATUS, 16'h8001, 16'h8001, "status busy");
        sw_wr(REG_PAGE, 16'hBEEF);
        sw_rd(REG_PAGE, 16'hFFFF, 16'h0012, "page while busy");
        wait_stall(1'b0, SIM_OP + 100, n);
        chk1("erase time", 1'b1, n + 20 >= SIM_OP && n <= SIM_OP + 20);
        sw_rd(REG_STATUS, 16'h8003, 16'h0002, "status done");
        chk16("dev errs", 16'd0, 16'(i_dev.errs));
        chk16("erase writes", 16'd6, 16'(dev_wr_cnt));
    endtask : t_erase
    task automatic t_program;
        int n;
        sw_wr(REG_INDEX, 16'h0000);
        for (int i = 0; i < ROW_WORDS; i++) sw_wr(REG_DATA, 16'hA500 + 16'(i));
        sw_wr(REG_CMD, 16'h0002);
        wait_stall(1'b1, 60, n);
        // Let the start write land in the array before looking at it
        repeat (2) @(posedge clk);
        #1;
        chk16("ctrl program", CTRL_PROGRAM | START_MASK, i_dev.ctrl);
        chk16("launches", 16'd2, 16'(i_dev.launches));
        for (int i = 0; i < ROW_WORDS; i++)
            chk16("latch word", 16'hA500 + 16'(i), i_dev.latch[i]);
        chk16("dev errs", 16'd0, 16'(i_dev.errs));
        // Reset in mid-operation must have dropped the stall two edges later
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk1("stall in reset", 1'b0, cpu_stall);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        sw_rd(REG_STATUS, 16'hFFFF, 16'h0000, "status reset again");
        sw_rd(REG_PAGE, 16'hFFFF, 16'h0000, "page reset again");
    endtask : t_program
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_and_regs();
        t_bad_cmd();
        t_erase();
        t_program();
        end_of_test();
    end
endmodule : flash_row_program_sequencer_tb_top

// >>> flash_seq_pkg.sv
// Package for the flash row sequencer controller: offsets, fields, timing.
// Assumes a 100 MHz clock and a device reached over a simple register port.
package flash_seq_pkg;
    // Device register indices (device side word map)
    localparam logic [3:0] DEV_CTRL      = 4'h0;
    localparam logic [3:0] DEV_KEY       = 4'h1;
    localparam logic [3:0] DEV_PAGE      = 4'h2;
    localparam logic [3:0] DEV_OFFSET    = 4'h3;
    localparam logic [3:0] DEV_LATCH     = 4'h4;
    // Control field positions and values
    localparam int         START_BIT     = 15;
    localparam int         WRITE_ENABLE_BIT_BIT      = 14;
    localparam logic [15:0] CTRL_ERASE   = 16'h4041;
    localparam logic [15:0] CTRL_PROGRAM = 16'h4001;
    localparam logic [15:0] START_MASK   = 16'h8000;
    localparam logic [15:0] KEY_FIRST    = 16'h0055;
    localparam logic [15:0] KEY_SECOND   = 16'h00AA;
    // Row geometry
    localparam int         ROW_WORDS     = 32;
    localparam logic [5:0] ROW_LAST      = 6'h1F;
    // Own register map of the controller
    localparam logic [3:0] REG_CMD       = 4'h0;
    localparam logic [3:0] REG_PAGE      = 4'h1;
    localparam logic [3:0] REG_OFFSET    = 4'h2;
    localparam logic [3:0] REG_STATUS    = 4'h3;
    localparam logic [3:0] REG_DATA      = 4'h4;
    localparam logic [3:0] REG_INDEX     = 4'h5;
    localparam int         CMD_ERASE_BIT = 0;
    localparam int         CMD_PROG_BIT  = 1;
    // Timing: operation time and stall
    localparam int         OP_TIME_US    = 2000;
    localparam int         CLK_MHZ       = 100;
    localparam int         OP_CYCLES     = OP_TIME_US * CLK_MHZ;
    localparam int         CNT_W         = 20;
endpackage : flash_seq_pkg

// >>> op_timer.sv
// Operation timer: counts a fixed number of cycles after a start pulse.
// Assumes start is a single-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
module op_timer
    import flash_seq_pkg::*;
#(
    parameter logic [flash_seq_pkg::CNT_W-1:0] LIMIT = flash_seq_pkg::CNT_W'(flash_seq_pkg::OP_CYCLES)
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    // Whole state of the timer
    typedef struct packed
    {
        logic             busy;
        logic             done;
        logic [CNT_W-1:0] count;
    } timer_state_type;

    timer_state_type state;
    timer_state_type next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_state      = state;
        next_state.done = 1'b0;
        if (start)
        begin
            // Restart from zero
            next_state.busy  = 1'b1;
            next_state.count = '0;
        end
        else if (state.busy)
        begin
            if (state.count == LIMIT - CNT_W'(1))
            begin
                next_state.busy = 1'b0;
                next_state.done = 1'b1;
            end
            else
            begin
                next_state.count = state.count + CNT_W'(1);
            end
        end
    end

    // Registered state, frozen while enable is low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
        end
        else if (enable)
        begin
            state <= next_state;
        end
    end

    assign busy = state.busy;
    assign done = state.done;
endmodule : op_timer
